/* File: async_serial_control.v */
/*
  Asynchronous serial port: control registers, baud generator, transmitter, receiver and
  pin takeover, reached over an AHB-Lite slave. Assumes one slave on the bus and pins that
  are synchronous to hclk; the port logic supplies its own direction bits and pin data.
*/
`include "serial_ctl_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module async_serial_control (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // port side of the shared pins
  input  wire        tx_pin_dir_bit,
  input  wire        rx_pin_dir_bit,
  input  wire        port_tx_data,
  input  wire        port_rx_data,
  // shared pins
  output reg         tx_line_pin_o,
  output reg         tx_line_pin_oe,
  input  wire        rx_line_pin_i,
  output reg         rx_line_pin_o,
  output reg         rx_line_pin_oe,
  // cpu requests
  output reg         tx_req,
  output reg         rx_req
);

  localparam [1:0] TXK_IDLE = 2'h0;
  localparam [1:0] TXK_DATA = 2'h1;
  localparam [1:0] TXK_PRE  = 2'h2;
  localparam [1:0] TXK_BRK  = 2'h3;
  localparam [1:0] RX_WAIT  = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_BITS  = 2'h2;

  // ==========================================================
  // helper functions
  function is_at;
    input [9:0] idx;
    input [7:0] reg_idx;
    begin
      is_at = (idx == {2'h0, reg_idx});
    end
  endfunction

  // frame is sent lsb first: start, data, optional parity in msb slot, stop
  function [10:0] make_frame;
    input [8:0] d;
    input       nine;
    input       par;
    input       odd;
    reg         p7;
    reg         p8;
    begin
      p7 = ^d[6:0] ^ odd;
      p8 = ^d[7:0] ^ odd;
      case ({nine, par})
        2'b00:   make_frame = {2'b11, d[7:0], 1'b0};
        2'b10:   make_frame = {1'b1, d[8:0], 1'b0};
        2'b01:   make_frame = {2'b11, p7, d[6:0], 1'b0};
        default: make_frame = {1'b1, p8, d[7:0], 1'b0};
      endcase
    end
  endfunction

  // ==========================================================
  // registers and their fields
  reg  [7:0]  ctrl_one_reg;
  reg  [7:0]  ctrl_two_reg;
  reg  [7:0]  baud_reg;
  reg  [8:0]  tx_buf_reg;
  reg  [8:0]  rx_buf_reg;
  reg         tx_empty_flag;
  reg         tx_done_flag;
  reg         rx_full_flag;
  reg         idle_flag;
  reg         overrun_flag;
  reg         frame_err_flag;
  reg         parity_err_flag;
  reg         wake_clr;

  wire loopback_sel         = ctrl_one_reg[`C1_LOOP];
  wire module_on            = ctrl_one_reg[`C1_MODULE_ON];
  wire tx_polarity_flip     = ctrl_one_reg[`C1_TX_INV];
  wire nine_sel             = ctrl_one_reg[`C1_NINE];
  wire wake_addr_sel        = ctrl_one_reg[`C1_WAKE_ADDR];
  wire idle_count_start_sel = ctrl_one_reg[`C1_IDLE_AFTER];
  wire parity_on            = ctrl_one_reg[`C1_PARITY_ON];
  wire odd_parity_sel       = ctrl_one_reg[`C1_ODD];
  wire tx_on                = ctrl_two_reg[`C2_TX_ON];
  wire rx_on                = ctrl_two_reg[`C2_RX_ON];
  wire rx_standby           = ctrl_two_reg[`C2_STANDBY];
  wire send_brk             = ctrl_two_reg[`C2_BRK];
  wire [3:0] char_len       = nine_sel ? `CHAR_LEN_9 : `CHAR_LEN_8;

  // ==========================================================
  // ahb-lite slave: writes take no wait state, reads take one
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg  [9:0] idx_reg;
  reg  [31:0] rd_mux;
  wire       addr_ok = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg     <= 10'h000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_pend_reg <= addr_ok & ~hwrite;
      if (addr_ok) begin
        idx_reg   <= haddr[11:2];
        hreadyout <= hwrite;
      end else if (rd_pend_reg) begin
        hreadyout <= 1'b1;
        hrdata    <= rd_mux;
      end
    end
  end

  wire wr_c1   = wr_pend_reg & is_at(idx_reg, `IDX_CTRL_ONE);
  wire wr_c2   = wr_pend_reg & is_at(idx_reg, `IDX_CTRL_TWO);
  wire wr_data = wr_pend_reg & is_at(idx_reg, `IDX_DATA);
  wire wr_baud = wr_pend_reg & is_at(idx_reg, `IDX_BAUD);
  wire rd_data = rd_pend_reg & is_at(idx_reg, `IDX_DATA);

  // read mux, unmapped words read as zero
  always @* begin
    rd_mux = 32'h00000000;
    if (is_at(idx_reg, `IDX_CTRL_ONE))
      rd_mux[7:0] = ctrl_one_reg;
    else if (is_at(idx_reg, `IDX_CTRL_TWO))
      rd_mux[7:0] = ctrl_two_reg;
    else if (is_at(idx_reg, `IDX_STATUS))
      rd_mux[7:0] = {tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag,
                     overrun_flag, 1'b0, frame_err_flag, parity_err_flag};
    else if (is_at(idx_reg, `IDX_DATA))
      rd_mux[8:0] = rx_buf_reg;
    else if (is_at(idx_reg, `IDX_BAUD))
      rd_mux[7:0] = baud_reg;
  end

  // ==========================================================
  // control registers; a software write of standby beats the hardware wake
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one_reg <= `CTRL_ONE_RST;
      ctrl_two_reg <= `CTRL_TWO_RST;
      baud_reg     <= `BAUD_RST;
      tx_buf_reg   <= 9'h000;
    end else begin
      if (wr_c1)
        ctrl_one_reg <= hwdata[7:0];
      if (wake_clr)
        ctrl_two_reg[`C2_STANDBY] <= 1'b0;
      if (wr_c2) begin
        ctrl_two_reg[7:4] <= hwdata[7:4];
        ctrl_two_reg[1:0] <= hwdata[1:0];
        // enables ignored while the module is off, guarding a misuse
        if (module_on)
          ctrl_two_reg[3:2] <= hwdata[3:2];
      end
      if (wr_data)
        tx_buf_reg <= hwdata[8:0];
      if (wr_baud)
        baud_reg <= hwdata[7:0];
    end
  end

  // ==========================================================
  // baud generator: rt tick at sixteen times the bit rate
  reg  [7:0] rt_cnt_reg;
  reg  [3:0] tx_rt_reg;
  wire       rt_tick  = module_on & (rt_cnt_reg == baud_reg);
  wire       tx_tick  = rt_tick & (tx_rt_reg == `RT_LAST);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rt_cnt_reg <= 8'h00;
      tx_rt_reg  <= 4'h0;
    end else if (!module_on) begin
      rt_cnt_reg <= 8'h00;
      tx_rt_reg  <= 4'h0;
    end else begin
      rt_cnt_reg <= rt_tick ? 8'h00 : rt_cnt_reg + 8'h01;
      if (rt_tick)
        tx_rt_reg <= tx_rt_reg + 4'h1;
    end
  end

  // ==========================================================
  // transmitter: a new slot is chosen only when the current one ends
  reg  [10:0] tx_shift_reg;
  reg  [3:0]  tx_left_reg;
  reg  [1:0]  tx_kind_reg;
  reg         pre_pend_reg;
  reg         brk_req_reg;
  reg         brk_tail_reg;
  reg         tx_on_d_reg;
  wire        tx_load = tx_tick & (tx_left_reg == 4'h1);
  wire        brk_go  = tx_on & (send_brk | brk_req_reg);
  wire        data_go = tx_on & ~tx_empty_flag & ~brk_go & ~brk_tail_reg & ~pre_pend_reg;
  wire        tx_line = tx_shift_reg[0] ^ tx_polarity_flip;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_shift_reg  <= 11'h7ff;
      tx_left_reg   <= 4'h1;
      tx_kind_reg   <= TXK_IDLE;
      pre_pend_reg  <= 1'b0;
      brk_req_reg   <= 1'b0;
      brk_tail_reg  <= 1'b0;
      tx_on_d_reg   <= 1'b0;
      tx_empty_flag <= 1'b1;
      tx_done_flag  <= 1'b1;
    end else if (!module_on) begin
      tx_shift_reg  <= 11'h7ff;
      tx_left_reg   <= 4'h1;
      tx_kind_reg   <= TXK_IDLE;
      pre_pend_reg  <= 1'b0;
      brk_req_reg   <= 1'b0;
      brk_tail_reg  <= 1'b0;
      tx_on_d_reg   <= 1'b0;
      tx_empty_flag <= 1'b1;
      tx_done_flag  <= 1'b1;
    end else begin
      tx_on_d_reg <= tx_on;
      // each rising enable queues a preamble, also mid-character
      if (tx_on & ~tx_on_d_reg)
        pre_pend_reg <= 1'b1;
      // a short break pulse is latched so a slot boundary cannot miss it
      if (wr_c2 & hwdata[`C2_BRK])
        brk_req_reg <= 1'b1;
      if (wr_data)
        tx_empty_flag <= 1'b0;
      if (tx_tick && tx_left_reg != 4'h1) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_left_reg  <= tx_left_reg - 4'h1;
      end
      if (tx_load) begin
        if (brk_go) begin
          tx_shift_reg <= 11'h000;
          tx_left_reg  <= char_len;
          tx_kind_reg  <= TXK_BRK;
          brk_req_reg  <= 1'b0;
          brk_tail_reg <= 1'b1;
          pre_pend_reg <= 1'b0;
        end else if (brk_tail_reg) begin
          tx_shift_reg <= 11'h7ff;
          tx_left_reg  <= 4'h1;
          tx_kind_reg  <= TXK_PRE;
          brk_tail_reg <= 1'b0;
        end else if (pre_pend_reg & tx_on) begin
          tx_shift_reg <= 11'h7ff;
          tx_left_reg  <= char_len;
          tx_kind_reg  <= TXK_PRE;
          pre_pend_reg <= 1'b0;
        end else if (data_go) begin
          tx_shift_reg  <= make_frame(tx_buf_reg, nine_sel, parity_on, odd_parity_sel);
          tx_left_reg   <= char_len;
          tx_kind_reg   <= TXK_DATA;
          tx_empty_flag <= 1'b1;
        end else begin
          // disabled or nothing queued: line rests at one, or at zero with tx_polarity_flip
          tx_shift_reg <= 11'h7ff;
          tx_left_reg  <= 4'h1;
          tx_kind_reg  <= TXK_IDLE;
        end
      end
      tx_done_flag <= tx_empty_flag & (tx_kind_reg == TXK_IDLE) & ~pre_pend_reg
                      & ~brk_req_reg & ~send_brk & ~brk_tail_reg;
    end
  end

  // ==========================================================
  // receiver: samples each bit at mid-point of sixteen rt ticks
  reg  [1:0]  rx_state_reg;
  reg  [3:0]  rx_rt_reg;
  reg  [3:0]  rx_cnt_reg;
  reg  [9:0]  rx_sh_reg;
  reg  [3:0]  idle_cnt_reg;
  reg         idle_armed_reg;
  wire        rx_in     = loopback_sel ? tx_line : rx_line_pin_i;
  wire        rx_run    = module_on & rx_on;
  wire [9:0]  sh_next   = {rx_in, rx_sh_reg[9:1]};
  wire [9:0]  fld       = nine_sel ? sh_next : {1'b1, sh_next[9:1]};
  wire        stop_ok   = nine_sel ? fld[9] : fld[8];
  wire [8:0]  chr       = nine_sel ? fld[8:0] : {fld[7], fld[7:0]};
  wire        chr_msb   = chr[8];
  wire        par_bad   = parity_on & ((nine_sel ? ^fld[8:0] : ^fld[7:0]) != odd_parity_sel);
  wire        bit_smp   = rt_tick & (rx_rt_reg == `RT_LAST);
  wire        rx_done   = rx_run & (rx_state_reg == RX_BITS) & bit_smp & (rx_cnt_reg == 4'h1);
  wire        count_one = bit_smp & rx_in & (idle_cnt_reg != char_len) &
                          ((rx_state_reg == RX_WAIT) |
                           ((rx_state_reg == RX_BITS) & ~idle_count_start_sel));
  wire        idle_hit  = count_one & (idle_cnt_reg == char_len - 4'h1);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg    <= RX_WAIT;
      rx_rt_reg       <= 4'h0;
      rx_cnt_reg      <= 4'h0;
      rx_sh_reg       <= 10'h000;
      idle_cnt_reg    <= 4'h0;
      idle_armed_reg  <= 1'b0;
      rx_buf_reg      <= 9'h000;
      rx_full_flag    <= 1'b0;
      idle_flag       <= 1'b0;
      overrun_flag    <= 1'b0;
      frame_err_flag  <= 1'b0;
      parity_err_flag <= 1'b0;
      wake_clr        <= 1'b0;
    end else begin
      wake_clr <= 1'b0;
      // reading data clears receiver flags; a new event this cycle wins
      if (rd_data) begin
        rx_full_flag    <= 1'b0;
        idle_flag       <= 1'b0;
        overrun_flag    <= 1'b0;
        frame_err_flag  <= 1'b0;
        parity_err_flag <= 1'b0;
      end
      if (!rx_run) begin
        rx_state_reg <= RX_WAIT;
        rx_rt_reg    <= 4'h0;
        idle_cnt_reg <= 4'h0;
      end else if (rt_tick) begin
        rx_rt_reg <= rx_rt_reg + 4'h1;
        if (count_one)
          idle_cnt_reg <= idle_cnt_reg + 4'h1;
        else if (bit_smp & ~rx_in & (rx_state_reg == RX_BITS) & ~idle_count_start_sel)
          idle_cnt_reg <= 4'h0;
        case (rx_state_reg)
          RX_WAIT: begin
            if (!rx_in) begin
              rx_state_reg <= RX_START;
              rx_rt_reg    <= 4'h0;
              idle_cnt_reg <= 4'h0;
            end
          end
          RX_START: begin
            if (rx_rt_reg == `RT_MID) begin
              rx_state_reg <= rx_in ? RX_WAIT : RX_BITS;
              rx_rt_reg    <= 4'h0;
              rx_cnt_reg   <= char_len - 4'h1;
            end
          end
          RX_BITS: begin
            if (bit_smp) begin
              rx_sh_reg  <= sh_next;
              rx_cnt_reg <= rx_cnt_reg - 4'h1;
              if (rx_cnt_reg == 4'h1)
                rx_state_reg <= RX_WAIT;
            end
          end
          default: rx_state_reg <= RX_WAIT;
        endcase
      end
      // a finished character
      if (rx_done) begin
        if (rx_standby) begin
          if (wake_addr_sel & chr_msb) begin
            wake_clr       <= 1'b1;
            rx_buf_reg     <= chr;
            rx_full_flag   <= 1'b1;
            idle_armed_reg <= 1'b1;
          end
        end else if (rx_full_flag & ~rd_data) begin
          overrun_flag <= 1'b1;
        end else begin
          rx_buf_reg      <= chr;
          rx_full_flag    <= 1'b1;
          idle_armed_reg  <= 1'b1;
          frame_err_flag  <= ~stop_ok;
          parity_err_flag <= par_bad;
        end
      end
      // an idle character; the one that wakes the receiver raises no flag
      if (rx_run & idle_hit) begin
        if (rx_standby & ~wake_addr_sel) begin
          wake_clr <= 1'b1;
        end else if (idle_armed_reg & ~rx_standby) begin
          idle_flag      <= 1'b1;
          idle_armed_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // pin takeover and cpu requests, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_line_pin_o  <= 1'b1;
      tx_line_pin_oe <= 1'b0;
      rx_line_pin_o  <= 1'b0;
      rx_line_pin_oe <= 1'b0;
      tx_req         <= 1'b0;
      rx_req         <= 1'b0;
    end else begin
      tx_line_pin_o  <= module_on ? tx_line : port_tx_data;
      tx_line_pin_oe <= module_on | tx_pin_dir_bit;
      rx_line_pin_o  <= port_rx_data;
      rx_line_pin_oe <= ~module_on & rx_pin_dir_bit;
      tx_req <= module_on & ((tx_empty_flag & ctrl_two_reg[`C2_TXE_IE]) |
                             (tx_done_flag & ctrl_two_reg[`C2_TXD_IE]));
      rx_req <= ~rx_standby & ((rx_full_flag & ctrl_two_reg[`C2_RXF_IE]) |
                               (idle_flag & ctrl_two_reg[`C2_IDLE_IE]));
    end
  end

endmodule

`default_nettype wire

/* File: async_serial_control_sva.sv */
/* port checker for the serial control block: bus answers, pin takeover, bit timing.
   bound from tb_top; assumes 16 hclk per bit or slower and hready tied to hreadyout. */
`timescale 1ns/100ps
`default_nettype none
module async_serial_control_sva (
  // bus side
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // pin side
  input wire logic       tx_pin_dir_bit,
  input wire logic       rx_pin_dir_bit,
  input wire logic       port_tx_data,
  input wire logic       tx_line_pin_o,
  input wire logic       tx_line_pin_oe,
  input wire logic       rx_line_pin_oe,
  input wire logic       tx_req
);
  // ====================
  // bus answers
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel & hready & htrans[1];
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_ready_pulse: assert property (!hreadyout |=> hreadyout)
    else $error("stall longer than one cycle");
  // ====================
  // pins: direction bits only count while the module is off
  a_rx_pin_free: assert property (tx_line_pin_oe && !$past(tx_pin_dir_bit) |-> !rx_line_pin_oe)
    else $error("receive pin driven while module on");
  a_rx_pin_input: assert property (rx_line_pin_oe |-> $past(rx_pin_dir_bit))
    else $error("receive pin driven without direction bit");
  a_port_pass: assert property (!tx_line_pin_oe |-> tx_line_pin_o == $past(port_tx_data))
    else $error("transmit pin not given to port");
  a_req_module_on: assert property (tx_req |-> tx_line_pin_oe)
    else $error("transmit request with module off");
  // a serial level holds for eight more cycles; dropping the module ends the check
  a_bit_width: assert property ($changed(tx_line_pin_o) && $past(tx_line_pin_oe)
    && !$past(tx_pin_dir_bit) |=> ($stable(tx_line_pin_o) || !tx_line_pin_oe)[*8])
    else $error("transmit level shorter than a bit");
endmodule
`default_nettype wire

/* File: serial_ctl_defines.vh */
/*
  Constants for the asynchronous serial control block: register indices, field positions,
  reset values and bit timing. Assumes it is included by its bare name from design files.
*/
`ifndef SERIAL_CTL_DEFINES_VH
`define SERIAL_CTL_DEFINES_VH

// ============================================================
// register indices (byte address is four times the index)
`define IDX_CTRL_ONE   8'h13
`define IDX_CTRL_TWO   8'h14
`define IDX_STATUS     8'h16
`define IDX_DATA       8'h17
`define IDX_BAUD       8'h18

// ============================================================
// first control register fields
`define C1_LOOP        7
`define C1_MODULE_ON   6
`define C1_TX_INV      5
`define C1_NINE        4
`define C1_WAKE_ADDR   3
`define C1_IDLE_AFTER  2
`define C1_PARITY_ON   1
`define C1_ODD         0

// ============================================================
// second control register fields
`define C2_TXE_IE      7
`define C2_TXD_IE      6
`define C2_RXF_IE      5
`define C2_IDLE_IE     4
`define C2_TX_ON       3
`define C2_RX_ON       2
`define C2_STANDBY     1
`define C2_BRK         0

// ============================================================
// status register fields
`define ST_TX_EMPTY    7
`define ST_TX_DONE     6
`define ST_RX_FULL     5
`define ST_IDLE        4
`define ST_OVERRUN     3
`define ST_FRAME_ERR   1
`define ST_PARITY_ERR  0

// ============================================================
// reset values and timing
`define CTRL_ONE_RST   8'h00
`define CTRL_TWO_RST   8'h00
`define BAUD_RST       8'h81
`define RT_LAST        4'hf
`define RT_MID         4'h7
`define CHAR_LEN_8     4'ha
`define CHAR_LEN_9     4'hb

`endif

/* File: serial_line_partner.sv */
/* remote serial end: decodes frames on the block's transmit line, sends frames to its
   receive line. assumes BIT_CYC hclk per bit and a line that idles high. */
`timescale 1ns/100ps
`default_nettype none
module serial_line_partner #(
  parameter int BIT_CYC = 16
) (
  // clock and lines
  input  wire logic clk,
  input  wire logic line_in,
  input  wire logic nine,
  output var  logic line_out
);
  logic [8:0] rx_char;
  logic       stop_ok;
  int         rx_cnt = 0;
  int         i;
  initial line_out = 1'b1;
  // one frame per falling edge, sampled mid-bit, lsb first
  always begin
    @(negedge line_in);
    rx_char = '0;
    repeat (BIT_CYC / 2) @(posedge clk);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CYC) @(posedge clk);
      rx_char[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge clk);
    stop_ok = line_in;
    rx_cnt++;
  end
  // idle gap bits first, so the far end can answer slowly
  task automatic send_char(input logic [8:0] c, input logic n9, input int gap);
    logic [10:0] f;
    f = n9 ? {1'b1, c, 1'b0} : {2'b11, c[7:0], 1'b0};
    repeat (gap * BIT_CYC) @(posedge clk);
    for (int k = 0; k < 11; k++) begin
      @(posedge clk);
      line_out <= f[k];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
/* self-checking bench for the serial control block: bus master tasks, a remote serial
   end on the pins, random data among fixed corner cases. assumes one bus slave. */
`timescale 1ns/100ps
`default_nettype none
`include "serial_ctl_defines.vh"
module tb_top;
  // ====================
  // signals and map
  localparam logic [31:0] A1 = {22'h0, `IDX_CTRL_ONE, 2'b00};
  localparam logic [31:0] A2 = {22'h0, `IDX_CTRL_TWO, 2'b00};
  localparam logic [31:0] AS = {22'h0, `IDX_STATUS, 2'b00};
  localparam logic [31:0] AD = {22'h0, `IDX_DATA, 2'b00};
  localparam logic [31:0] AB = {22'h0, `IDX_BAUD, 2'b00};
  localparam int BITC = 16; // divisor 0 gives 16 hclk per bit
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_s, v, d;
  logic        hreadyout, hresp, rdy_s, tx_req, rx_req, nine_mode = 0;
  logic        tx_pin_dir_bit = 0, rx_pin_dir_bit = 0, port_rx_data = 0, port_tx_data = 1;
  logic        tx_line_pin_o, tx_line_pin_oe, rx_line_pin_i, rx_line_pin_o, rx_line_pin_oe;
  logic [2:0]  m;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, k, n;
  always #25 hclk = ~hclk;
  async_serial_control u_async_serial_control (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .tx_pin_dir_bit, .rx_pin_dir_bit, .port_tx_data, .port_rx_data, .tx_line_pin_o,
    .tx_line_pin_oe, .rx_line_pin_i, .rx_line_pin_o, .rx_line_pin_oe, .tx_req, .rx_req);
  serial_line_partner #(.BIT_CYC(BITC)) u_serial_line_partner (.clk(hclk),
    .line_in(tx_line_pin_o), .nine(nine_mode), .line_out(rx_line_pin_i));
  // ====================
  // bus tasks; answers sampled mid-cycle so the edge never races the design
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
  end
  task automatic bus(input logic wr, input logic [31:0] a, wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (!rdy_s);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (!rdy_s);
  endtask
  task automatic wr(input logic [31:0] a, wd);
    bus(1'b1, a, wd);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a, msk, e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd_s & msk);
  endtask
  // expected character as the far end decodes it, parity in the msb slot
  function automatic logic [8:0] exp_char(input logic [8:0] c, input logic n9, pe, od);
    logic [8:0] r;
    r = n9 ? c : {1'b0, c[7:0]};
    if (pe && n9) r[8] = ^r[7:0] ^ od;
    else if (pe) r[7] = ^r[6:0] ^ od;
    return r;
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  // ====================
  // main sequence
  initial begin
    v = $urandom(32'ha00b7073);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ctrl_one", A1, 32'hff, `CTRL_ONE_RST);
    rdchk("ctrl_two", A2, 32'hff, `CTRL_TWO_RST);
    rdchk("status", AS, 32'hc0, 32'hc0);
    rdchk("unmapped", 32'h7c, 32'hffff_ffff, 32'h0);
    // every direction setting, module off then on
    for (k = 0; k < 4; k++) begin
      {tx_pin_dir_bit, rx_pin_dir_bit} <= k[1:0];
      port_rx_data <= k[0];
      port_tx_data <= k[0];
      wr(A1, 32'h00);
      repeat (2) @(posedge hclk);
      chk("tx_oe_off", k[1], tx_line_pin_oe);
      chk("rx_oe_off", k[0], rx_line_pin_oe);
      chk("tx_pin_port", k[0], tx_line_pin_o);
      chk("rx_pin_port", k[0], rx_line_pin_o);
      wr(A1, 32'h40);
      repeat (2) @(posedge hclk);
      chk("tx_oe_on", 1, tx_line_pin_oe);
      chk("rx_oe_on", 0, rx_line_pin_oe);
    end
    // a low port level above looks like a start bit to the far end; let that frame pass
    repeat (8 * BITC) @(posedge hclk);
    {tx_pin_dir_bit, rx_pin_dir_bit} <= 2'b00;
    wr(AB, 32'h0);
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      wr(A2, {24'h0, d[7:4], 4'h0});
      rdchk("irq_en", A2, 32'hff, {24'h0, d[7:4], 4'h0});
    end
    wr(A2, 32'h80);
    repeat (2) @(posedge hclk);
    chk("tx_req", 1, tx_req);
    n = u_serial_line_partner.rx_cnt;
    wr(A2, 32'h0c);
    repeat (12 * BITC) @(posedge hclk);
    chk("preamble", n, u_serial_line_partner.rx_cnt);
    // every character format; format changes only between characters
    for (k = 0; k < 6; k++) begin
      m = {k > 2, k % 3 != 0, k % 3 == 2};
      nine_mode <= m[2];
      wr(A1, {24'h0, 8'h40 | {3'b0, m[2], 2'b0, m[1:0]}});
      d = $urandom;
      n = u_serial_line_partner.rx_cnt;
      wr(AD, {23'h0, d[8:0]});
      for (int w = 0; w < 400 && u_serial_line_partner.rx_cnt == n; w++) @(posedge hclk);
      chk("tx_count", n + 1, u_serial_line_partner.rx_cnt);
      chk("tx_char", exp_char(d[8:0], m[2], m[1], m[0]), u_serial_line_partner.rx_char);
      chk("stop_bit", 1, u_serial_line_partner.stop_ok);
      repeat (BITC) @(posedge hclk);
    end
    nine_mode <= 1'b0;
    // module dropped right after a data write, before the character goes out
    wr(A2, 32'h88);
    wr(AD, 32'h0a5);
    wr(A1, 32'h00);
    rdchk("status_off", AS, 32'hc0, 32'hc0);
    chk("tx_req_off", 0, tx_req);
    // loop mode needs both directions enabled
    wr(A1, 32'hc0);
    wr(A2, 32'h0c);
    d = $urandom;
    wr(AD, {24'h0, d[7:0]});
    repeat (26 * BITC) @(posedge hclk);
    rdchk("loop_full", AS, 32'h20, 32'h20);
    rdchk("loop_data", AD, 32'h1ff, {23'h0, d[7], d[7:0]});
    // reception, then standby with address-mark wakeup
    wr(A1, 32'h48);
    wr(A2, 32'h2c);
    u_serial_line_partner.send_char({1'b0, d[7:0]}, 1'b0, 1);
    repeat (BITC) @(posedge hclk);
    chk("rx_req", 1, rx_req);
    rdchk("rx_data", AD, 32'h1ff, {23'h0, d[7], d[7:0]});
    wr(A2, 32'h2e);
    u_serial_line_partner.send_char({2'b00, d[6:0]}, 1'b0, 2);
    repeat (BITC) @(posedge hclk);
    chk("standby_req", 0, rx_req);
    rdchk("standby_drop", AS, 32'h20, 32'h0);
    u_serial_line_partner.send_char({2'b01, d[6:0]}, 1'b0, 0);
    repeat (BITC) @(posedge hclk);
    rdchk("wake_clear", A2, 32'h02, 32'h0);
    wr(A2, 32'h28);
    rdchk("rx_off_keep", AS, 32'h20, 32'h20);
    rdchk("wake_data", AD, 32'hff, {24'h0, 1'b1, d[6:0]});
    // odd parity selected, even parity sent: the error must come with the data
    wr(A1, 32'h43);
    wr(A2, 32'h2c);
    u_serial_line_partner.send_char({1'b0, ^d[6:0], d[6:0]}, 1'b0, 1);
    repeat (BITC) @(posedge hclk);
    rdchk("parity_err", AS, 32'h23, 32'h21);
    // inverted idle, held break, then release
    wr(A1, 32'h60);
    repeat (10) @(posedge hclk);
    chk("inv_idle", 0, tx_line_pin_o);
    wr(A2, 32'h09);
    repeat (6 * BITC) @(posedge hclk);
    chk("brk", 1, tx_line_pin_o);
    repeat (8 * BITC) @(posedge hclk);
    chk("brk_held", 1, tx_line_pin_o);
    wr(A2, 32'h08);
    repeat (24 * BITC) @(posedge hclk);
    chk("brk_end", 0, tx_line_pin_o);
    end_of_test;
  end
endmodule
bind async_serial_control async_serial_control_sva u_async_serial_control_sva (.hclk,
  .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .tx_pin_dir_bit,
  .rx_pin_dir_bit, .port_tx_data, .tx_line_pin_o, .tx_line_pin_oe, .rx_line_pin_oe, .tx_req);
`default_nettype wire
